// file: hw/dlpit_rx.sv
`timescale 1ns/1ps
// Function
// - A high bit-mapping select decodes the JEIDA arrangement, a low or open pin the VESA one.
// - Adaptive luminance runs only while its enable pin is high.
// - With the no-signal pin high, a lost input is replaced by a self-made test pattern.
// - The backlight status pin is pulled low when normal and released open on a fault.
// - Two links, each with lanes A to D and a clock, carry the pixels and run together.
// - Line and frame framing come from data enable alone; syncs are ignored.
module dlpit_rx #(
	parameter int unsigned FIFO_DEPTH = dlpit_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                   core_clk_i,
	input  wire logic                   rstn_i,
	// Link clocks and deserialised lanes
	input  wire logic                   link1_clock_i,
	input  wire logic                   link2_clock_i,
	input  wire dlpit_pkg::dlpit_lanes_s link1_lanes_i,
	input  wire dlpit_pkg::dlpit_lanes_s link2_lanes_i,
	// Option pins
	input  wire logic                   bit_map_jeida_i,
	input  wire logic                   adaptive_luminance_enable_i,
	input  wire logic                   self_generated_test_pattern_i,
	input  wire logic                   backlight_fault_i,
	// Pixel stream
	output dlpit_pkg::dlpit_pair_s      pix_data_o,
	output logic                        pix_valid_o,
	input  wire logic                   pix_ready_i,
	// Backlight status, open drain
	output logic                        backlight_status_o,
	output logic                        backlight_status_oe_o,
	// Status
	output logic                        adaptive_luminance_active_o,
	output dlpit_pkg::dlpit_mode_e      display_mode_o,
	output logic                        frame_start_o,
	output logic [dlpit_pkg::CNT_W-1:0] line_count_o,
	output logic                        line_len_err_o,
	output logic                        line_blank_err_o,
	output logic                        frame_lines_err_o,
	output logic                        pix_drop_o
);

	localparam int unsigned W = dlpit_pkg::CNT_W;

	if (FIFO_DEPTH < 2) begin : g_bad_depth
		$error("dlpit_rx: FIFO_DEPTH must be at least 2");
	end

	// Synchronised pins
	dlpit_pkg::dlpit_lanes_s l1_s, l2_s;
	logic [1:0]              lclk_s;
	logic                    jeida_s, lum_s, pat_sel_s, fault_s;

	dlpit_sync #(.WIDTH(dlpit_pkg::LINK_SYNC_W)) u_sync_link (
		.core_clk_i (core_clk_i),
		.rstn_i     (rstn_i),
		.async_i    ({link2_lanes_i, link1_lanes_i, link2_clock_i, link1_clock_i}),
		.sync_o     ({l2_s, l1_s, lclk_s})
	);

	dlpit_sync #(.WIDTH(dlpit_pkg::CTL_SYNC_W)) u_sync_ctl (
		.core_clk_i (core_clk_i),
		.rstn_i     (rstn_i),
		.async_i    ({backlight_fault_i, self_generated_test_pattern_i,
		              adaptive_luminance_enable_i, bit_map_jeida_i}),
		.sync_o     ({fault_s, pat_sel_s, lum_s, jeida_s})
	);

	// Link clock edges and presence
	logic [1:0]   lclk_prev_q, lclk_prev_d;
	logic [W-1:0] idle_q [2];
	logic [W-1:0] idle_d [2];
	logic         sig_ok_q, sig_ok_d;
	logic [1:0]   lrise;

	// Both links must tick, else the input counts as lost
	always_comb begin
		lclk_prev_d = lclk_s;
		lrise       = lclk_s & ~lclk_prev_q;
		for (int i = 0; i < 2; i++) begin
			if (lrise[i]) begin
				idle_d[i] = '0;
			end else if (idle_q[i] != dlpit_pkg::NOSIG_LIMIT) begin
				idle_d[i] = idle_q[i] + dlpit_pkg::CNT_ONE;
			end else begin
				idle_d[i] = idle_q[i];
			end
		end
		sig_ok_d = (idle_q[0] != dlpit_pkg::NOSIG_LIMIT) && (idle_q[1] != dlpit_pkg::NOSIG_LIMIT);
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lclk_prev_q <= '0;
			idle_q[0]   <= dlpit_pkg::NOSIG_LIMIT;
			idle_q[1]   <= dlpit_pkg::NOSIG_LIMIT;
			sig_ok_q    <= 1'b0;
		end else begin
			lclk_prev_q <= lclk_prev_d;
			idle_q[0]   <= idle_d[0];
			idle_q[1]   <= idle_d[1];
			sig_ok_q    <= sig_ok_d;
		end
	end

	// Line and frame tracker; only data enable is looked at, never the sync bits
	dlpit_pkg::dlpit_line_e ln_q, ln_d;
	logic [W-1:0] hcnt_q, hcnt_d, blank_q, blank_d, lines_q, lines_d;
	logic         fs_q, fs_d, len_err_q, len_err_d;
	logic         blk_err_q, blk_err_d, fl_err_q, fl_err_d;
	logic         de;
	logic         gap;

	always_comb begin
		ln_d      = ln_q;
		hcnt_d    = hcnt_q;
		blank_d   = blank_q;
		lines_d   = lines_q;
		fs_d      = 1'b0;
		len_err_d = 1'b0;
		blk_err_d = 1'b0;
		fl_err_d  = 1'b0;
		de        = l1_s.c[dlpit_pkg::DE_BIT];
		gap       = (blank_q > dlpit_pkg::LINE_BLANK_MAX);
		if (!sig_ok_q) begin
			// Lost input: wait for a clean vertical gap again
			ln_d    = dlpit_pkg::LN_SEEK;
			blank_d = '0;
		end else if (lrise[0]) begin
			case (ln_q)
				dlpit_pkg::LN_SEEK: begin
					if (de && gap) begin
						ln_d    = dlpit_pkg::LN_ACTIVE;
						hcnt_d  = dlpit_pkg::CNT_ONE;
						lines_d = dlpit_pkg::CNT_ONE;
						fs_d    = 1'b1;
						blank_d = '0;
					end else if (de) begin
						blank_d = '0;
					end else if (blank_q != '1) begin
						blank_d = blank_q + dlpit_pkg::CNT_ONE;
					end
				end
				dlpit_pkg::LN_ACTIVE: begin
					if (de) begin
						hcnt_d = hcnt_q + dlpit_pkg::CNT_ONE;
					end else begin
						len_err_d = (hcnt_q != dlpit_pkg::ACTIVE_CLOCKS);
						ln_d      = dlpit_pkg::LN_BLANK;
						blank_d   = dlpit_pkg::CNT_ONE;
					end
				end
				dlpit_pkg::LN_BLANK: begin
					if (!de) begin
						if (blank_q != '1) begin
							blank_d = blank_q + dlpit_pkg::CNT_ONE;
						end
					end else begin
						ln_d    = dlpit_pkg::LN_ACTIVE;
						hcnt_d  = dlpit_pkg::CNT_ONE;
						blank_d = '0;
						if (gap) begin
							// Long quiet spell ends the frame
							fl_err_d = (lines_q != dlpit_pkg::ACTIVE_LINES);
							lines_d  = dlpit_pkg::CNT_ONE;
							fs_d     = 1'b1;
						end else begin
							blk_err_d = (blank_q < dlpit_pkg::LINE_BLANK_MIN);
							lines_d   = lines_q + dlpit_pkg::CNT_ONE;
						end
					end
				end
				default: ln_d = dlpit_pkg::LN_SEEK;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ln_q      <= dlpit_pkg::LN_SEEK;
			hcnt_q    <= '0;
			blank_q   <= '0;
			lines_q   <= '0;
			fs_q      <= 1'b0;
			len_err_q <= 1'b0;
			blk_err_q <= 1'b0;
			fl_err_q  <= 1'b0;
		end else begin
			ln_q      <= ln_d;
			hcnt_q    <= hcnt_d;
			blank_q   <= blank_d;
			lines_q   <= lines_d;
			fs_q      <= fs_d;
			len_err_q <= len_err_d;
			blk_err_q <= blk_err_d;
			fl_err_q  <= fl_err_d;
		end
	end

	// Source select and pixel feed into the FIFO
	dlpit_pkg::dlpit_mode_e mode_q, mode_d;
	logic [W-1:0]           pdiv_q, pdiv_d, px_q, px_d;
	logic                   drop_q, drop_d;
	logic                   fifo_valid, fifo_ready;
	dlpit_pkg::dlpit_pair_s fifo_data;
	dlpit_pkg::dlpit_pix_s  bar;
	logic [2:0]             bar_idx;

	// Self-made frames pace themselves and stall on back-pressure; live pixels cannot wait
	always_comb begin
		mode_d     = dlpit_pkg::MODE_LIVE;
		pdiv_d     = pdiv_q;
		px_d       = px_q;
		drop_d     = 1'b0;
		fifo_valid = 1'b0;
		bar_idx    = px_q[dlpit_pkg::BAR_LSB +: 3];
		bar.r      = {8{bar_idx[2]}};
		bar.g      = {8{bar_idx[1]}};
		bar.b      = {8{bar_idx[0]}};
		fifo_data.first  = dlpit_pkg::dlpit_decode(l1_s, jeida_s);
		fifo_data.second = dlpit_pkg::dlpit_decode(l2_s, jeida_s);
		if (!sig_ok_q) begin
			mode_d = pat_sel_s ? dlpit_pkg::MODE_PATTERN : dlpit_pkg::MODE_BLACK;
		end
		if (mode_q == dlpit_pkg::MODE_LIVE) begin
			pdiv_d     = '0;
			px_d       = '0;
			fifo_valid = lrise[0] && de && (ln_q == dlpit_pkg::LN_ACTIVE || ln_d == dlpit_pkg::LN_ACTIVE);
			drop_d     = fifo_valid && !fifo_ready;
		end else begin
			if (mode_q == dlpit_pkg::MODE_PATTERN) begin
				fifo_data.first  = bar;
				fifo_data.second = bar;
			end else begin
				fifo_data = '0;
			end
			if (pdiv_q != dlpit_pkg::PAT_LAST) begin
				pdiv_d = pdiv_q + dlpit_pkg::CNT_ONE;
			end else if (fifo_ready) begin
				fifo_valid = 1'b1;
				pdiv_d     = '0;
				px_d       = (px_q == dlpit_pkg::ACTIVE_LAST) ? '0 : px_q + dlpit_pkg::CNT_ONE;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode_q <= dlpit_pkg::MODE_BLACK;
			pdiv_q <= '0;
			px_q   <= '0;
			drop_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			pdiv_q <= pdiv_d;
			px_q   <= px_d;
			drop_q <= drop_d;
		end
	end

	dlpit_fifo #(.WIDTH(dlpit_pkg::PAIR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk_i  (core_clk_i),
		.rstn_i      (rstn_i),
		.in_valid_i  (fifo_valid),
		.in_ready_o  (fifo_ready),
		.in_data_i   (fifo_data),
		.out_valid_o (pix_valid_o),
		.out_ready_i (pix_ready_i),
		.out_data_o  (pix_data_o)
	);

	// Option and backlight status flops
	logic lum_q, lum_d, st_oe_q, st_oe_d, st_q, st_d;

	always_comb begin
		lum_d   = lum_s;
		st_oe_d = !fault_s;
		st_d    = 1'b0;
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lum_q   <= 1'b0;
			st_oe_q <= 1'b0;
			st_q    <= 1'b0;
		end else begin
			lum_q   <= lum_d;
			st_oe_q <= st_oe_d;
			st_q    <= st_d;
		end
	end

	// Output wiring, all from flops
	assign adaptive_luminance_active_o = lum_q;
	assign backlight_status_o          = st_q;
	assign backlight_status_oe_o       = st_oe_q;
	assign display_mode_o              = mode_q;
	assign frame_start_o               = fs_q;
	assign line_count_o                = lines_q;
	assign line_len_err_o              = len_err_q;
	assign line_blank_err_o            = blk_err_q;
	assign frame_lines_err_o           = fl_err_q;
	assign pix_drop_o                  = drop_q;

endmodule

// file: inc/dlpit_pkg.sv
package dlpit_pkg;

	// Lane word as delivered per link clock by each deserialiser, lane A in the low bits
	localparam int unsigned LANE_BITS = 7;
	typedef struct packed {
		logic [LANE_BITS-1:0] d;
		logic [LANE_BITS-1:0] c;
		logic [LANE_BITS-1:0] b;
		logic [LANE_BITS-1:0] a;
	} dlpit_lanes_s;

	// One 24-bit pixel
	typedef struct packed {
		logic [7:0] r;
		logic [7:0] g;
		logic [7:0] b;
	} dlpit_pix_s;

	// Pixel pair, first link in the low half
	typedef struct packed {
		dlpit_pix_s second;
		dlpit_pix_s first;
	} dlpit_pair_s;

	localparam int unsigned PAIR_W      = $bits(dlpit_pair_s);
	localparam int unsigned LINK_SYNC_W = 2 * $bits(dlpit_lanes_s) + 2;
	localparam int unsigned CTL_SYNC_W  = 4;

	// Control lane field positions
	localparam int unsigned HS_BIT = 4;
	localparam int unsigned VS_BIT = 5;
	localparam int unsigned DE_BIT = 6;

	// Output display source
	typedef enum logic [1:0] {
		MODE_LIVE    = 2'h0,
		MODE_BLACK   = 2'h1,
		MODE_PATTERN = 2'h2
	} dlpit_mode_e;

	// Line tracker states
	typedef enum logic [1:0] {
		LN_SEEK   = 2'h0,
		LN_ACTIVE = 2'h1,
		LN_BLANK  = 2'h2
	} dlpit_line_e;

	// Line and frame limits, in link clocks and lines
	localparam int unsigned CNT_W = 16;
	localparam logic [CNT_W-1:0] CNT_ONE        = 16'h0001;
	localparam logic [CNT_W-1:0] ACTIVE_CLOCKS  = 16'h03C0;
	localparam logic [CNT_W-1:0] ACTIVE_LAST    = 16'h03BF;
	localparam logic [CNT_W-1:0] LINE_BLANK_MIN = 16'h0064;
	localparam logic [CNT_W-1:0] LINE_BLANK_MAX = 16'h00F0;
	localparam logic [CNT_W-1:0] ACTIVE_LINES   = 16'h0438;

	// Time figures and derived core cycle counts
	localparam int unsigned CORE_PERIOD_NS  = 100;
	localparam int unsigned NOSIG_TIME_NS   = 20000;
	localparam int unsigned NOSIG_CYCLES    = (NOSIG_TIME_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	localparam int unsigned PAT_PIX_TIME_NS = 800;
	localparam int unsigned PAT_DIV_CYCLES  = (PAT_PIX_TIME_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	localparam logic [CNT_W-1:0] NOSIG_LIMIT = CNT_W'(NOSIG_CYCLES);
	localparam logic [CNT_W-1:0] PAT_LAST    = CNT_W'(PAT_DIV_CYCLES - 1);

	// Test pattern bar index position in the column count
	localparam int unsigned BAR_LSB  = 7;
	localparam int unsigned FIFO_DEPTH = 16;

	// Bit arrangement decode; lane D gives the two LSBs per colour for JEIDA and the two MSBs for VESA
	function automatic dlpit_pix_s dlpit_decode(input dlpit_lanes_s l, input logic jeida);
		dlpit_pix_s p;
		logic [5:0] r6;
		logic [5:0] g6;
		logic [5:0] b6;
		r6 = l.a[5:0];
		g6 = {l.b[4:0], l.a[6]};
		b6 = {l.c[3:0], l.b[6:5]};
		if (jeida) begin
			p.r = {r6, l.d[1:0]};
			p.g = {g6, l.d[3:2]};
			p.b = {b6, l.d[5:4]};
		end else begin
			p.r = {l.d[1:0], r6};
			p.g = {l.d[3:2], g6};
			p.b = {l.d[5:4], b6};
		end
		return p;
	endfunction

endpackage

// file: hw/dlpit_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for pins from outside the core clock domain
module dlpit_sync #(
	parameter int unsigned WIDTH = 1
) (
	// Clock and reset
	input  wire logic             core_clk_i,
	input  wire logic             rstn_i,
	// Asynchronous in, synchronised out
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// First stage feeds only the second
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;

endmodule

// file: hw/dlpit_fifo.sv
`timescale 1ns/1ps
// Pixel FIFO with a registered output stage
module dlpit_fifo #(
	parameter int unsigned WIDTH = 48,
	parameter int unsigned DEPTH = 16
) (
	// Clock and reset
	input  wire logic             core_clk_i,
	input  wire logic             rstn_i,
	// Fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);

	localparam int unsigned AW = $clog2(DEPTH);

	// Pointer wrap relies on a power-of-two depth
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("dlpit_fifo: DEPTH must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
	logic [AW:0]      cnt_q, cnt_d;
	logic             ov_q, ov_d;
	logic [WIDTH-1:0] od_q, od_d;
	logic             push, pop;

	// Full counts the array only; the output stage holds one more
	always_comb begin
		in_ready_o = (cnt_q != (AW+1)'(DEPTH));
		push  = in_valid_i && in_ready_o;
		pop   = (cnt_q != '0) && (!ov_q || out_ready_i);
		wr_d  = push ? wr_q + 1'b1 : wr_q;
		rd_d  = pop ? rd_q + 1'b1 : rd_q;
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		ov_d  = pop ? 1'b1 : (out_ready_i ? 1'b0 : ov_q);
		od_d  = pop ? mem[rd_q] : od_q;
	end

	// Storage, no reset on the array
	always_ff @(posedge core_clk_i) begin
		if (push) begin
			mem[wr_q] <= in_data_i;
		end
	end

	// Pointers and output stage
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
			ov_q  <= 1'b0;
			od_q  <= '0;
		end else begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
			ov_q  <= ov_d;
			od_q  <= od_d;
		end
	end

	assign out_valid_o = ov_q;
	assign out_data_o  = od_q;

endmodule

// file: sim/dlpit_rx_assertions.sv
`timescale 1ns/1ps
// Watches status pins, framing outputs and the stream handshake of the receiver
module dlpit_rx_assertions (
	// Clock and reset
	input wire logic                        core_clk_i,
	input wire logic                        rstn_i,
	// Inputs watched
	input wire logic                        backlight_fault_i,
	input wire logic                        adaptive_luminance_enable_i,
	input wire logic                        pix_ready_i,
	// Outputs watched
	input wire dlpit_pkg::dlpit_pair_s      pix_data_o,
	input wire logic                        pix_valid_o,
	input wire logic                        backlight_status_o,
	input wire logic                        backlight_status_oe_o,
	input wire logic                        adaptive_luminance_active_o,
	input wire logic                        frame_start_o,
	input wire logic [dlpit_pkg::CNT_W-1:0] line_count_o,
	input wire logic                        frame_lines_err_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);

	// Open drain: the pin value never leaves low, only the enable moves
	a_status_low_only: assert property (backlight_status_o == 1'b0)
		else $error("status pin driven high");
	a_fault_opens: assert property ($rose(backlight_fault_i) |-> ##[1:4] !backlight_status_oe_o)
		else $error("status pin not released on fault");
	a_normal_drives: assert property (!backlight_fault_i [*6] |-> backlight_status_oe_o)
		else $error("status pin not pulled low when normal");

	// Luminance feature follows its pin, sync latency allowed
	a_lum_enabled: assert property (adaptive_luminance_enable_i [*6] |-> adaptive_luminance_active_o)
		else $error("luminance feature off while enabled");
	a_lum_disabled: assert property (!adaptive_luminance_enable_i [*6] |-> !adaptive_luminance_active_o)
		else $error("luminance feature on while disabled");

	// Line counting restarts at one and otherwise only steps by one
	a_frame_first_line: assert property (frame_start_o |-> line_count_o == 16'h0001)
		else $error("frame start without line count one");
	a_count_steps: assert property ((line_count_o != $past(line_count_o)) && !frame_start_o
		|-> line_count_o == $past(line_count_o) + 16'h0001)
		else $error("line count jumped");
	a_frame_err_aligned: assert property (frame_lines_err_o |-> frame_start_o)
		else $error("frame line error away from frame start");

	// A stalled pair stays put until taken
	a_stream_holds: assert property (pix_valid_o && !pix_ready_i |=> pix_valid_o && $stable(pix_data_o))
		else $error("pixel pair changed while stalled");
endmodule

// file: sim/dlpit_link_tx.sv
`timescale 1ns/1ps
// Far-end transmitter: two links in lockstep, one lane word per link clock
module dlpit_link_tx (
	// Link pins only; reserved connector positions are never driven
	output logic                    link1_clock_o,
	output logic                    link2_clock_o,
	output dlpit_pkg::dlpit_lanes_s link1_lanes_o,
	output dlpit_pkg::dlpit_lanes_s link2_lanes_o,
	// Bit arrangement in force
	input  wire logic               map_jeida_i
);
	dlpit_pkg::dlpit_pair_s exp_q[$];
	logic [7:0]             idx_q;
	logic                   sync_q;

	// Idle links at time zero
	initial begin
		link1_clock_o = 1'b0;
		link2_clock_o = 1'b0;
		link1_lanes_o = '0;
		link2_lanes_o = '0;
		idx_q = 8'h00;
		sync_q = 1'b0;
	end

	// Splits a pixel into lane bits; syncs toggle because the receiver must ignore them
	function automatic dlpit_pkg::dlpit_lanes_s enc(input dlpit_pkg::dlpit_pix_s p, input logic de);
		logic [5:0] r6, g6, b6, lo;
		r6 = map_jeida_i ? p.r[7:2] : p.r[5:0];
		g6 = map_jeida_i ? p.g[7:2] : p.g[5:0];
		b6 = map_jeida_i ? p.b[7:2] : p.b[5:0];
		lo = map_jeida_i ? {p.b[1:0], p.g[1:0], p.r[1:0]} : {p.b[7:6], p.g[7:6], p.r[7:6]};
		return {{1'b0, lo}, {de, sync_q, ~sync_q, b6[5:2]}, {b6[1:0], g6[5:1]}, {g6[0], r6}};
	endfunction

	// Data launched on the fall, taken on the rise; both links share each edge
	// Period scaled to the core clock; no spread spectrum, so its limits hold trivially
	task automatic run(input int n, input logic de);
		dlpit_pkg::dlpit_pair_s p;
		#13;
		for (int i = 0; i < n; i++) begin
			p = {idx_q ^ 8'h5A, idx_q, ~idx_q, idx_q, ~idx_q, 8'hA5};
			link1_clock_o = 1'b0;
			link2_clock_o = 1'b0;
			link1_lanes_o = enc(p.first, de);
			link2_lanes_o = enc(p.second, de);
			if (de) exp_q.push_back(p);
			idx_q = idx_q + 8'h01;
			sync_q = ~sync_q;
			#400;
			link1_clock_o = 1'b1;
			link2_clock_o = 1'b1;
			#400;
		end
		// Stale words would hide a receiver that samples late
		link1_lanes_o = ~link1_lanes_o;
		link2_lanes_o = ~link2_lanes_o;
	endtask
endmodule

// file: sim/test_dual_link_panel_input_timing.sv
`timescale 1ns/1ps
// Runs both links through framing, overflow and loss, checking the receiver's outputs
module test_dual_link_panel_input_timing;
	logic                        core_clk_i, rstn_i, link1_clock_i, link2_clock_i;
	dlpit_pkg::dlpit_lanes_s     link1_lanes_i, link2_lanes_i;
	logic                        bit_map_jeida_i, adaptive_luminance_enable_i, self_generated_test_pattern_i;
	logic                        backlight_fault_i, pix_ready_i, pix_valid_o, backlight_status_o;
	logic                        backlight_status_oe_o, adaptive_luminance_active_o, frame_start_o;
	logic                        line_len_err_o, line_blank_err_o, frame_lines_err_o, pix_drop_o;
	dlpit_pkg::dlpit_pair_s      pix_data_o;
	dlpit_pkg::dlpit_mode_e      display_mode_o;
	logic [dlpit_pkg::CNT_W-1:0] line_count_o;
	int                          num_errors, total_checks, n_len, n_blank, n_ferr, n_fs, n_drop, n_pop;
	logic                        chk_en, blk_chk, pat_chk, bar_seen;

	dlpit_link_tx u_tx (.link1_clock_o(link1_clock_i), .link2_clock_o(link2_clock_i),
		.link1_lanes_o(link1_lanes_i), .link2_lanes_o(link2_lanes_i), .map_jeida_i(bit_map_jeida_i));

	dlpit_rx #(.FIFO_DEPTH(dlpit_pkg::FIFO_DEPTH)) dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.link1_clock_i(link1_clock_i), .link2_clock_i(link2_clock_i), .link1_lanes_i(link1_lanes_i),
		.link2_lanes_i(link2_lanes_i), .bit_map_jeida_i(bit_map_jeida_i),
		.adaptive_luminance_enable_i(adaptive_luminance_enable_i),
		.self_generated_test_pattern_i(self_generated_test_pattern_i), .backlight_fault_i(backlight_fault_i),
		.pix_data_o(pix_data_o), .pix_valid_o(pix_valid_o), .pix_ready_i(pix_ready_i),
		.backlight_status_o(backlight_status_o), .backlight_status_oe_o(backlight_status_oe_o),
		.adaptive_luminance_active_o(adaptive_luminance_active_o), .display_mode_o(display_mode_o),
		.frame_start_o(frame_start_o), .line_count_o(line_count_o), .line_len_err_o(line_len_err_o),
		.line_blank_err_o(line_blank_err_o), .frame_lines_err_o(frame_lines_err_o), .pix_drop_o(pix_drop_o));

	// 10 MHz core clock
	initial begin
		core_clk_i = 1'b0;
		forever #50 core_clk_i = ~core_clk_i;
	end

	task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Bounded wait; running out ends the run
	task automatic wait_mode(input dlpit_pkg::dlpit_mode_e m, input int lim);
		for (int i = 0; i < lim && display_mode_o !== m; i++) @(posedge core_clk_i);
		if (display_mode_o !== m) begin
			num_errors++;
			finish_test();
		end
	endtask

	// Every channel of a bar is fully off or fully on
	function automatic logic is_bar(input logic [47:0] v);
		is_bar = 1'b1;
		for (int i = 0; i < 6; i++) is_bar &= (v[8*i +: 8] == 8'h00) || (v[8*i +: 8] == 8'hFF);
	endfunction

	// Pulse counters and per-transfer comparisons
	always @(posedge core_clk_i) begin
		n_len += line_len_err_o;
		n_blank += line_blank_err_o;
		n_ferr += frame_lines_err_o;
		n_fs += frame_start_o;
		n_drop += pix_drop_o;
		if (pix_valid_o && pix_ready_i) begin
			n_pop++;
			if (chk_en) begin
				check("pair pending", u_tx.exp_q.size() != 0, 1'b1);
				if (u_tx.exp_q.size() != 0) check("pixel pair", pix_data_o, u_tx.exp_q.pop_front());
			end
			if (blk_chk) check("black pair", pix_data_o, 48'h0);
			if (pat_chk) check("bar colours", is_bar(pix_data_o), 1'b1);
			bar_seen |= pat_chk && (pix_data_o != 48'h0);
		end
	end

	// Main sequence
	initial begin
		{rstn_i, bit_map_jeida_i, adaptive_luminance_enable_i, backlight_fault_i} = 4'h0;
		self_generated_test_pattern_i = 1'b0;
		{pix_ready_i, chk_en, blk_chk, pat_chk, bar_seen} = 5'h10;
		{num_errors, total_checks, n_len, n_blank, n_ferr, n_fs, n_drop, n_pop} = '0;
		repeat (16) @(posedge core_clk_i);
		check("reset mode", display_mode_o, dlpit_pkg::MODE_BLACK);
		check("reset valid", pix_valid_o, 1'b0);
		rstn_i <= 1'b1;
		// Backlight fault, then the luminance pin high and low; the dimming pulse never enters this block
		@(posedge core_clk_i) backlight_fault_i <= 1'b1;
		repeat (6) @(posedge core_clk_i);
		check("status enable", backlight_status_oe_o, 1'b0);
		check("status pin", backlight_status_o, 1'b0);
		backlight_fault_i <= 1'b0;
		adaptive_luminance_enable_i <= 1'b1;
		repeat (6) @(posedge core_clk_i);
		check("status enable", backlight_status_oe_o, 1'b1);
		check("luminance", adaptive_luminance_active_o, 1'b1);
		adaptive_luminance_enable_i <= 1'b0;
		repeat (6) @(posedge core_clk_i);
		check("luminance", adaptive_luminance_active_o, 1'b0);
		// Vertical gap brings the link live; lines of legal and short length follow
		fork
			u_tx.run(250, 1'b0);
			wait_mode(dlpit_pkg::MODE_LIVE, 2000);
		join
		chk_en <= 1'b1;
		u_tx.run(960, 1'b1);
		check("frame starts", n_fs, 1);
		u_tx.run(100, 1'b0);
		u_tx.run(10, 1'b1);
		u_tx.run(10, 1'b0);
		@(posedge core_clk_i) bit_map_jeida_i <= 1'b1;
		u_tx.run(40, 1'b0);
		u_tx.run(20, 1'b1);
		u_tx.run(100, 1'b0);
		check("line count", line_count_o, 16'h0003);
		check("length errors", n_len, 2);
		check("blank errors", n_blank, 1);
		check("pairs left", u_tx.exp_q.size(), 0);
		// Sink stalls: FIFO and output stage fill, the rest drop
		chk_en <= 1'b0;
		n_pop = 0;
		@(posedge core_clk_i) pix_ready_i <= 1'b0;
		u_tx.run(30, 1'b1);
		u_tx.run(2, 1'b0);
		@(posedge core_clk_i) pix_ready_i <= 1'b1;
		u_tx.run(100, 1'b0);
		check("drops", n_drop, 30 - dlpit_pkg::FIFO_DEPTH - 1);
		check("drained", n_pop, dlpit_pkg::FIFO_DEPTH + 1);
		u_tx.exp_q.delete();
		chk_en <= 1'b1;
		// Second frame after a long gap reports the four-line first frame, counting the stalled line, as a wrong line total
		u_tx.run(250, 1'b0);
		u_tx.run(4, 1'b1);
		u_tx.run(4, 1'b0);
		check("frame starts", n_fs, 2);
		check("frame line errors", n_ferr, 1);
		check("line count", line_count_o, 16'h0001);
		// Links stop: grounded pin blanks, raised pin shows bars
		chk_en <= 1'b0;
		wait_mode(dlpit_pkg::MODE_BLACK, 400);
		blk_chk <= 1'b1;
		repeat (100) @(posedge core_clk_i);
		blk_chk <= 1'b0;
		self_generated_test_pattern_i <= 1'b1;
		wait_mode(dlpit_pkg::MODE_PATTERN, 20);
		check("pattern mode", display_mode_o, dlpit_pkg::MODE_PATTERN);
		pat_chk <= 1'b1;
		repeat (1200) @(posedge core_clk_i);
		check("bar seen", bar_seen, 1'b1);
		finish_test();
	end
endmodule

bind dlpit_rx dlpit_rx_assertions u_chk (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
	.backlight_fault_i(backlight_fault_i), .adaptive_luminance_enable_i(adaptive_luminance_enable_i),
	.pix_ready_i(pix_ready_i), .pix_data_o(pix_data_o), .pix_valid_o(pix_valid_o),
	.backlight_status_o(backlight_status_o), .backlight_status_oe_o(backlight_status_oe_o),
	.adaptive_luminance_active_o(adaptive_luminance_active_o), .frame_start_o(frame_start_o),
	.line_count_o(line_count_o), .frame_lines_err_o(frame_lines_err_o));
